// ---- dv/lrcd_bus_model.sv ----
// Memory model on the multiplexed address and data bus
`timescale 1ns/1ps
`default_nettype none
module lrcd_bus_model (
	// Clock
	input wire logic clk_i,
	// Bus from the core
	input wire logic ale_i,
	input wire logic rd_n_i,
	input wire logic ad_oe_i,
	input wire logic [7:0] addr_hi_i,
	input wire logic [7:0] ad_i,
	// Data back and address seen
	output logic [7:0] data_o,
	output logic [15:0] addr_o
);
	// ==================================================================
	// Address capture and read data
	logic [15:0] addr = 16'h0000;
	logic [7:0] last = 8'h00;
	// Low byte shares the data lines, so it is caught while the latch strobe is up
	always_ff @(posedge clk_i) begin
		if (ale_i && ad_oe_i) begin
			addr <= {addr_hi_i, ad_i};
		end
		if (!rd_n_i) begin
			last <= data_o;
		end
	end
	// A released bus shows the inverse of the last byte, never a stale copy
	assign data_o = rd_n_i ? ~last : addr[7:0] ^ addr[15:8] ^ 8'h5A;
	assign addr_o = addr;
endmodule : lrcd_bus_model
`default_nettype wire

// ---- dv/tb_cpu8_logic_rotate_control_decode.sv ----
// Self-checking bench of the logic, rotate and control decoder
`timescale 1ns/1ps
`default_nettype none
module tb_cpu8_logic_rotate_control_decode;
	import lrcd_pkg::*;
	// ==================================================================
	// Signals
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic opc_valid_i = 1'b0;
	logic [7:0] opc_i = 8'h00;
	logic [7:0] src_reg_i = 8'h00;
	logic [15:0] hl_i = 16'h0000;
	logic [15:0] pc_i = 16'h0000;
	logic trap_i = 1'b0;
	logic [2:0] vec_irq_i = 3'h0;
	logic general_irq_in_i = 1'b0;
	logic serial_in_i = 1'b0;
	logic hold_i = 1'b0;
	logic busy_o, done_o, int_enable_o, irq_ack_o, hold_ack_o, power_down_o;
	logic serial_out_pin_o, ale_o, rd_n_o, ad_oe_o;
	logic [2:0] src_sel_o, int_mask_o, irq_vec_o;
	logic [7:0] acc_o, flags_o, addr_hi_o, ad_out_o, ad_in_i;
	logic [15:0] seen_addr;
	logic [31:0] seed = 32'h53A764D7;
	logic [31:0] w;
	logic [7:0] acc = 8'h00;
	logic [7:0] flg = 8'h00;
	logic [2:0] msk = 3'h7;
	logic ie = 1'b0;
	logic sout = 1'b0;
	int bad_count = 0;
	int comparisons = 0;

	lrcd_core #(.DATA_W(8)) lrcd_core_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.opc_valid_i(opc_valid_i), .opc_i(opc_i), .src_reg_i(src_reg_i), .hl_i(hl_i),
		.pc_i(pc_i), .ad_in_i(ad_in_i), .trap_i(trap_i), .vec_irq_i(vec_irq_i),
		.general_irq_in_i(general_irq_in_i), .serial_in_i(serial_in_i), .hold_i(hold_i),
		.busy_o(busy_o), .done_o(done_o), .src_sel_o(src_sel_o), .acc_o(acc_o),
		.flags_o(flags_o), .int_enable_o(int_enable_o), .int_mask_o(int_mask_o),
		.irq_ack_o(irq_ack_o), .irq_vec_o(irq_vec_o), .hold_ack_o(hold_ack_o),
		.power_down_o(power_down_o), .serial_out_pin_o(serial_out_pin_o), .ale_o(ale_o),
		.rd_n_o(rd_n_o), .addr_hi_o(addr_hi_o), .ad_out_o(ad_out_o), .ad_oe_o(ad_oe_o));
	lrcd_bus_model lrcd_bus_model_inst (.clk_i(clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o),
		.ad_oe_i(ad_oe_o), .addr_hi_i(addr_hi_o), .ad_i(ad_out_o), .data_o(ad_in_i),
		.addr_o(seen_addr));

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	// ==================================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [7:0] szp(input logic [7:0] r, input logic ac, input logic cy);
		return {r[7], r == 8'h00, 1'b0, ac, 1'b0, ~^r, 1'b0, cy};
	endfunction : szp

	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : mem_byte

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	// Expected effect of one opcode on the bench's copy of the state
	task automatic predict(input logic [7:0] op, input logic [7:0] v);
		logic [7:0] r;
		logic c;
		logic [1:0] f;
		c = flg[0];
		f = op[4:3];
		r = f == FN_AND ? acc & v : f == FN_XOR ? acc ^ v : f == FN_OR ? acc | v : acc - v;
		if (op[7] && op[5] && (!op[6] || op[2:0] == REG_MEM)) begin
			flg = szp(r, f == FN_AND ? acc[3] | v[3] : f == FN_CMP && acc[3:0] < v[3:0],
				f == FN_CMP && acc < v);
			if (f != FN_CMP) begin
				acc = r;
			end
		end else if (op[7:5] == 3'h0 && op[2:0] == ROT_LOW) begin
			case (f)
				ROT_LEFT_CIRC: {c, acc} = {acc, acc[7]};
				ROT_RIGHT_CIRC: {acc, c} = {acc[0], acc};
				ROT_LEFT_CARRY: {c, acc} = {acc, c};
				default: {acc, c} = {c, acc};
			endcase
			flg[0] = c;
		end else begin
			case (op)
				OPC_INV_ACC: acc = ~acc;
				OPC_SET_CARRY: flg[0] = 1'b1;
				OPC_INV_CARRY: flg[0] = ~c;
				// Exact only for a decimal byte with both adjust flags clear
				OPC_DEC_ADJ: flg = szp(acc, 1'b0, c);
				OPC_ALLOW_INT: ie = 1'b1;
				OPC_BLOCK_INT: ie = 1'b0;
				OPC_READ_MASK: acc = {serial_in_i, vec_irq_i, ie, msk};
				OPC_WRITE_MASK: begin
					msk = acc[SM_MASK_EN] ? acc[2:0] : msk;
					sout = acc[SM_SOD_EN] ? acc[SM_SOD_VAL] : sout;
				end
				default: ;
			endcase
		end
	endtask : predict

	task automatic run(input logic [7:0] op, input logic [7:0] v);
		int k;
		logic [31:0] x;
		logic [15:0] ea;
		logic mf;
		logic [15:0] n;
		k = 0;
		x = rnd();
		mf = op[7] && op[5] && op[2:0] == REG_MEM;
		ea = op[6] ? ~x[15:0] : x[15:0];
		n = op == OPC_HALT ? 16'h5 : mf ? 16'h7 : 16'h4;
		@(posedge clk_i);
		opc_valid_i <= 1'b1;
		opc_i <= op;
		src_reg_i <= op[2:0] == REG_ACC ? acc : v;
		hl_i <= x[15:0];
		pc_i <= ~x[15:0];
		@(posedge clk_i);
		opc_valid_i <= 1'b0;
		do begin
			@(posedge clk_i);
			k++;
			if (k == 1) begin
				chk("source", 16'(src_sel_o), 16'(op[2:0]));
			end
		end while (done_o !== 1'b1 && power_down_o !== 1'b1 && k < 12);
		predict(op, mf ? mem_byte(ea) : op[2:0] == REG_ACC ? acc : v);
		chk("cycles", 16'(k), n);
		chk("acc", 16'(acc_o), 16'(acc));
		chk("flags", 16'(flags_o), 16'(flg));
		chk("enable", 16'(int_enable_o), 16'(ie));
		chk("mask", 16'(int_mask_o), 16'(msk));
		chk("serial", 16'(serial_out_pin_o), 16'(sout));
		if (mf) begin
			chk("address", seen_addr, ea);
		end
	endtask : run

	task automatic load(input logic [7:0] x);
		run(8'hA0, 8'h00);
		run(8'hB0, x);
	endtask : load

	task automatic irq(input logic t, input logic [2:0] v, input logic g, input logic [2:0] ev);
		int k;
		k = 0;
		@(posedge clk_i);
		trap_i <= t;
		vec_irq_i <= v;
		general_irq_in_i <= g;
		do begin
			@(negedge clk_i);
			k++;
		end while (irq_ack_o !== 1'b1 && k < 12);
		// Dropped inside the acknowledge cycle so a level source is not taken twice
		trap_i = 1'b0;
		vec_irq_i = 3'h0;
		general_irq_in_i = 1'b0;
		chk("ack", 16'(irq_ack_o), 16'h1);
		chk("vector", 16'(irq_vec_o), 16'(ev));
		chk("enable", 16'(int_enable_o), 16'h0);
		ie = 1'b0;
		@(negedge clk_i);
		chk("powered", 16'(power_down_o), 16'h0);
	endtask : irq

	// ==================================================================
	// Watchdog
	initial begin
		#(25 * 20000);
		bad_count++;
		complete_run();
	end

	// ==================================================================
	// Main sequence
	initial begin
		// Reset held well past any start-up settling
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		chk("rst_acc", {acc_o, flags_o}, 16'h0000);
		chk("rst_ie", 16'(int_enable_o), 16'h0);
		chk("rst_mask", 16'(int_mask_o), 16'h7);
		chk("rst_sod", 16'(serial_out_pin_o), 16'h0);
		chk("rst_rd", 16'({rd_n_o, busy_o, power_down_o}), 16'h4);
		run(OPC_DEC_ADJ, 8'h00);
		$display("Test reset finished");
		for (int i = 0; i < 36; i++) begin
			w = rnd();
			run(8'hA8, w[7:0]);
			run(i < 32 ? {3'h5, 5'(i)} : {3'h7, 2'(i), 3'h6}, w[15:8]);
		end
		$display("Test logic table finished");
		for (int i = 0; i < 150; i++) begin
			w = rnd();
			case (w[9:8])
				2'h0: run({3'h5, w[4:0]}, w[23:16]);
				2'h1: run({3'h7, w[4:3], 3'h6}, w[23:16]);
				2'h2: run({3'h0, w[4:3], 3'h7}, w[23:16]);
				default: run({3'h1, w[4:3] == 2'h0 ? 2'h1 : w[4:3], 3'h7}, w[23:16]);
			endcase
		end
		$display("Test random finished");
		foreach (w[i]) begin
			if (i < 5) begin
				run(i == 0 ? OPC_NOP : i == 1 ? 8'h40 : i == 2 ? OPC_ALLOW_INT : OPC_BLOCK_INT, 8'h00);
			end
		end
		serial_in_i <= 1'b1;
		vec_irq_i <= 3'h5;
		run(OPC_READ_MASK, 8'h00);
		vec_irq_i <= 3'h0;
		load(8'hCA);
		run(OPC_WRITE_MASK, 8'h00);
		load(8'h4C);
		run(OPC_WRITE_MASK, 8'h00);
		$display("Test control finished");
		for (int i = 0; i < 3; i++) begin
			load(i == 0 ? 8'h0C : i == 1 ? 8'h0F : 8'h08);
			run(OPC_WRITE_MASK, 8'h00);
			run(OPC_ALLOW_INT, 8'h00);
			irq(1'b0, 3'h7, i != 2, i == 0 ? VEC_R65 : i == 1 ? VEC_GEN : VEC_R75);
		end
		run(OPC_HALT, 8'h00);
		irq(1'b1, 3'h0, 1'b0, VEC_TRAP);
		$display("Test interrupts finished");
		// Bus request raised only with no acknowledge under way
		@(posedge clk_i);
		hold_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("hold_ack", {hold_ack_o, power_down_o, ad_oe_o}, 16'h6);
		hold_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("hold_rel", {hold_ack_o, power_down_o}, 16'h0);
		run(OPC_NOP, 8'h00);
		$display("Test hold finished");
		complete_run();
	end
endmodule : tb_cpu8_logic_rotate_control_decode
`default_nettype wire

// ---- hw/lrcd_core.sv ----
// Sequencer and datapath for the logic, rotate, special and control groups
`timescale 1ns/1ps
`default_nettype none
module lrcd_core
	import lrcd_pkg::*;
#(
	parameter int DATA_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Instruction and operands
	input wire logic opc_valid_i,
	input wire logic [7:0] opc_i,
	input wire logic [7:0] src_reg_i,
	input wire logic [15:0] hl_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0] ad_in_i,
	// Interrupts and bus request
	input wire logic trap_i,
	input wire logic [2:0] vec_irq_i,
	input wire logic general_irq_in_i,
	input wire logic serial_in_i,
	input wire logic hold_i,
	// Status
	output logic busy_o,
	output logic done_o,
	output logic [2:0] src_sel_o,
	output logic [7:0] acc_o,
	output logic [7:0] flags_o,
	output logic int_enable_o,
	output logic [2:0] int_mask_o,
	output logic irq_ack_o,
	output logic [2:0] irq_vec_o,
	output logic hold_ack_o,
	output logic power_down_o,
	output logic serial_out_pin_o,
	// Address and data bus
	output logic ale_o,
	output logic rd_n_o,
	output logic [7:0] addr_hi_o,
	output logic [7:0] ad_out_o,
	output logic ad_oe_o
);
	if (DATA_W != 8) begin : g_bad_width
		$error("lrcd_core supports only an 8-bit data path");
	end

	typedef struct packed {
		lrcd_state_e st;
		lrcd_class_e cls;
		logic [1:0] fn;
		logic [2:0] cnt;
		logic [7:0] acc;
		logic [7:0] flags;
		logic ie;
		logic [2:0] mask;
		logic serial_out_pin;
		logic done;
		logic [2:0] src_sel;
		logic irq_ack;
		logic [2:0] irq_vec;
		logic ale;
		logic rd_n;
		logic [7:0] addr_hi;
		logic [7:0] ad_out;
		logic ad_oe;
	} lrcd_core_s;

	lrcd_core_s r;
	lrcd_core_s next_r;
	lrcd_dec_if dif ();
	lrcd_decode u_decode (.d(dif.dec));

	assign dif.opcode = opc_i;

	// ==================================================================
	// Helpers
	function automatic logic [7:0] lrcd_szp(input logic [7:0] res, input logic [7:0] f);
		logic [7:0] o;
		o = f;
		o[FLG_SIGN] = res[7];
		o[FLG_ZERO] = (res == 8'h00);
		o[FLG_PAR] = ~^res;
		return o;
	endfunction : lrcd_szp

	logic take;
	logic irq_hit;
	logic [2:0] irq_code;
	logic [7:0] operand;
	logic [8:0] diff;
	logic [7:0] res;
	logic [7:0] corr;

	always_comb begin
		irq_hit = 1'b1;
		irq_code = VEC_TRAP;
		if (trap_i) begin
			irq_code = VEC_TRAP;
		end else if (r.ie && vec_irq_i[2] && !r.mask[2]) begin
			irq_code = VEC_R75;
		end else if (r.ie && vec_irq_i[1] && !r.mask[1]) begin
			irq_code = VEC_R65;
		end else if (r.ie && vec_irq_i[0] && !r.mask[0]) begin
			irq_code = VEC_R55;
		end else if (r.ie && general_irq_in_i) begin
			irq_code = VEC_GEN;
		end else begin
			irq_hit = 1'b0;
		end
	end

	// ==================================================================
	// Next state
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.irq_ack = 1'b0;
		operand = (r.cls == CLS_LOGIC_REG) ? src_reg_i : ad_in_i;
		diff = {1'b0, r.acc} - {1'b0, operand};
		res = r.acc;
		corr = 8'h00;
		take = 1'b0;
		case (r.st)
			ST_IDLE: begin
				if (irq_hit) begin
					next_r.irq_ack = 1'b1;
					next_r.irq_vec = irq_code;
					next_r.ie = 1'b0;
				end else if (hold_i) begin
					next_r.st = ST_HOLD;
				end else if (opc_valid_i) begin
					take = 1'b1;
					next_r.st = ST_EXEC;
					next_r.cls = dif.cls;
					next_r.fn = dif.fn;
					next_r.src_sel = dif.src;
					next_r.cnt = dif.cycles - 3'h2;
				end
			end
			ST_EXEC: begin
				if (r.cnt == CNT_ADDR && (r.cls == CLS_LOGIC_MEM || r.cls == CLS_LOGIC_IMM)) begin
					next_r.ale = 1'b1;
					next_r.ad_oe = 1'b1;
					{next_r.addr_hi, next_r.ad_out} = (r.cls == CLS_LOGIC_MEM) ? hl_i : pc_i;
				end else begin
					next_r.ale = 1'b0;
					next_r.ad_oe = 1'b0;
				end
				// Read strobe spans the two data states of the operand cycle
				next_r.rd_n = !((r.cnt == 3'h2 || r.cnt == 3'h1)
					&& (r.cls == CLS_LOGIC_MEM || r.cls == CLS_LOGIC_IMM));
				if (r.cnt != 3'h0) begin
					next_r.cnt = r.cnt - 3'h1;
				end else begin
					next_r.done = 1'b1;
					next_r.st = ST_IDLE;
					case (r.cls)
						CLS_LOGIC_REG, CLS_LOGIC_MEM, CLS_LOGIC_IMM: begin
							case (r.fn)
								FN_AND: res = r.acc & operand;
								FN_XOR: res = r.acc ^ operand;
								FN_OR: res = r.acc | operand;
								default: res = diff[7:0];
							endcase
							next_r.flags = lrcd_szp(res, r.flags);
							next_r.flags[FLG_CARRY] = 1'b0;
							next_r.flags[FLG_HALF] = (r.fn == FN_AND) && (r.acc[3] | operand[3]);
							if (r.fn == FN_CMP) begin
								// Result only feeds the flags
								next_r.flags[FLG_CARRY] = diff[8];
								next_r.flags[FLG_HALF] = (r.acc[3:0] < operand[3:0]);
							end else begin
								next_r.acc = res;
							end
						end
						CLS_ROTATE: begin
							case (r.fn)
								ROT_LEFT_CIRC: begin
									next_r.acc = {r.acc[6:0], r.acc[7]};
									next_r.flags[FLG_CARRY] = r.acc[7];
								end
								ROT_RIGHT_CIRC: begin
									next_r.acc = {r.acc[0], r.acc[7:1]};
									next_r.flags[FLG_CARRY] = r.acc[0];
								end
								ROT_LEFT_CARRY: begin
									next_r.acc = {r.acc[6:0], r.flags[FLG_CARRY]};
									next_r.flags[FLG_CARRY] = r.acc[7];
								end
								default: begin
									next_r.acc = {r.flags[FLG_CARRY], r.acc[7:1]};
									next_r.flags[FLG_CARRY] = r.acc[0];
								end
							endcase
						end
						CLS_SPECIAL: begin
							case (r.fn)
								2'h1: next_r.acc = ~r.acc;
								2'h2: next_r.flags[FLG_CARRY] = 1'b1;
								2'h3: next_r.flags[FLG_CARRY] = ~r.flags[FLG_CARRY];
								default: begin
									if (r.acc[3:0] > 4'h9 || r.flags[FLG_HALF]) begin
										corr[3:0] = 4'h6;
									end
									if (r.acc > 8'h99 || r.flags[FLG_CARRY]) begin
										corr[7:4] = 4'h6;
										next_r.flags[FLG_CARRY] = 1'b1;
									end
									res = r.acc + corr;
									next_r.acc = res;
									next_r.flags = lrcd_szp(res, next_r.flags);
									next_r.flags[FLG_HALF] = (r.acc[3:0] > 4'h9);
								end
							endcase
						end
						CLS_ALLOW_INT: next_r.ie = 1'b1;
						CLS_BLOCK_INT: next_r.ie = 1'b0;
						CLS_READ_MASK: next_r.acc = {serial_in_i, vec_irq_i, r.ie, r.mask};
						CLS_WRITE_MASK: begin
							if (r.acc[SM_MASK_EN]) begin
								next_r.mask = r.acc[2:0];
							end
							if (r.acc[SM_SOD_EN]) begin
								next_r.serial_out_pin = r.acc[SM_SOD_VAL];
							end
						end
						CLS_HALT: next_r.st = ST_HALTED;
						default: next_r.acc = r.acc;
					endcase
				end
			end
			ST_HALTED: begin
				// Power-down ends only by an accepted interrupt or by reset
				if (irq_hit) begin
					next_r.st = ST_IDLE;
					next_r.irq_ack = 1'b1;
					next_r.irq_vec = irq_code;
					next_r.ie = 1'b0;
				end
			end
			ST_HOLD: begin
				if (!hold_i) begin
					next_r.st = ST_IDLE;
				end
			end
			default: next_r.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.cls <= CLS_NOP;
			r.acc <= ACC_RST;
			r.flags <= FLAGS_RST;
			r.mask <= MASK_RST;
			r.rd_n <= 1'b1;
			r.serial_out_pin <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign busy_o = (r.st == ST_EXEC);
	assign done_o = r.done;
	assign src_sel_o = r.src_sel;
	assign acc_o = r.acc;
	assign flags_o = r.flags;
	assign int_enable_o = r.ie;
	assign int_mask_o = r.mask;
	assign irq_ack_o = r.irq_ack;
	assign irq_vec_o = r.irq_vec;
	assign hold_ack_o = (r.st == ST_HOLD);
	assign power_down_o = (r.st == ST_HOLD) || (r.st == ST_HALTED);
	assign serial_out_pin_o = r.serial_out_pin;
	assign ale_o = r.ale;
	assign rd_n_o = r.rd_n;
	assign addr_hi_o = r.addr_hi;
	assign ad_out_o = r.ad_out;
	assign ad_oe_o = r.ad_oe;

	// ==================================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_reg_logic_len: assert property (take && dif.cls == CLS_LOGIC_REG |-> ##4 done_o)
		else $error("register logic op not done in 4 cycles");
	chk_mem_logic_rd: assert property (take && dif.cls == CLS_LOGIC_MEM
		|-> ##4 ale_o ##1 !rd_n_o ##1 !rd_n_o ##1 done_o)
		else $error("memory logic op bus cycle or length wrong");
	chk_imm_logic_len: assert property (take && dif.cls == CLS_LOGIC_IMM |-> ##7 done_o)
		else $error("immediate logic op not done in 7 cycles");
	chk_compare_keeps: assert property (done_o && r.fn == FN_CMP
		&& (r.cls == CLS_LOGIC_REG || r.cls == CLS_LOGIC_MEM || r.cls == CLS_LOGIC_IMM)
		|-> acc_o == $past(acc_o))
		else $error("compare changed the accumulator");
	chk_rotate_len: assert property (take && dif.cls == CLS_ROTATE |-> ##1 !done_o [*3] ##1 done_o)
		else $error("rotate not done in 4 cycles");
	chk_carry_rotate: assert property (done_o && r.cls == CLS_ROTATE && r.fn == ROT_LEFT_CARRY
		|-> acc_o[0] == $past(flags_o[FLG_CARRY]) && flags_o[FLG_CARRY] == $past(acc_o[7]))
		else $error("left rotate through carry wrong");
	chk_halt_power: assert property (take && dif.cls == CLS_HALT
		|-> !power_down_o [*5] ##1 power_down_o)
		else $error("halt did not power down after 5 cycles");
	chk_hold_power: assert property (hold_ack_o |-> power_down_o)
		else $error("bus grant without power-down");
	chk_ie_on_accept: assert property (irq_ack_o |-> !int_enable_o)
		else $error("interrupt enable kept after acceptance");
	chk_trap_first: assert property (irq_ack_o && $past(trap_i) |-> irq_vec_o == VEC_TRAP)
		else $error("unmaskable interrupt lost priority");
	chk_addr_split: assert property (ale_o && r.cls == CLS_LOGIC_MEM
		|-> {addr_hi_o, ad_out_o} == $past(hl_i))
		else $error("memory operand address not split correctly");
	chk_sod_reset: assert property (disable iff (1'b0) $past(sys_rst_i) |-> !serial_out_pin_o)
		else $error("serial output undefined after reset");

endmodule : lrcd_core
`default_nettype wire

// ---- hw/lrcd_dec_if.sv ----
// Opcode to decoded fields between the sequencer and the decoder
`timescale 1ns/1ps
`default_nettype none
interface lrcd_dec_if;
	import lrcd_pkg::*;
	logic [7:0] opcode;
	lrcd_class_e cls;
	logic [1:0] fn;
	logic [2:0] src;
	logic [2:0] dst;
	logic [2:0] cycles;
	modport seq (output opcode, input cls, fn, src, dst, cycles);
	modport dec (input opcode, output cls, fn, src, dst, cycles);
endinterface : lrcd_dec_if
`default_nettype wire

// ---- hw/lrcd_decode.sv ----
// Combinational opcode decoder for the logic, rotate, special and control groups
`timescale 1ns/1ps
`default_nettype none
module lrcd_decode
	import lrcd_pkg::*;
(
	// Opcode in, fields out
	lrcd_dec_if.dec d
);
	logic [7:0] op;

	always_comb begin
		op = d.opcode;
		d.src = op[SRC_LSB +: 3];
		d.dst = op[DST_LSB +: 3];
		d.fn = op[FN_LSB +: 2];
		d.cls = CLS_OTHER;
		d.cycles = CYC_SHORT;
		if (op[7:6] == GRP_LOGIC_REG && op[5:3 + 2] == LOGIC_TAG[2]) begin
			if (op[5] && op[2:0] == REG_MEM) begin
				d.cls = CLS_LOGIC_MEM;
				d.cycles = CYC_OPERAND;
			end else if (op[5]) begin
				d.cls = CLS_LOGIC_REG;
			end
		end else if (op[7:5] == GRP_LOGIC_IMM && op[2:0] == REG_MEM) begin
			d.cls = CLS_LOGIC_IMM;
			d.cycles = CYC_OPERAND;
		end else if (op[7:5] == 3'h0 && op[2:0] == ROT_LOW) begin
			d.cls = CLS_ROTATE;
		end else if (op == OPC_INV_ACC || op == OPC_SET_CARRY || op == OPC_INV_CARRY
				|| op == OPC_DEC_ADJ) begin
			d.cls = CLS_SPECIAL;
		end else if (op == OPC_ALLOW_INT) begin
			d.cls = CLS_ALLOW_INT;
		end else if (op == OPC_BLOCK_INT) begin
			d.cls = CLS_BLOCK_INT;
		end else if (op == OPC_READ_MASK) begin
			d.cls = CLS_READ_MASK;
		end else if (op == OPC_WRITE_MASK) begin
			d.cls = CLS_WRITE_MASK;
		end else if (op == OPC_NOP) begin
			d.cls = CLS_NOP;
		end else if (op == OPC_HALT) begin
			d.cls = CLS_HALT;
			d.cycles = CYC_HALT;
		end
	end

endmodule : lrcd_decode
`default_nettype wire

// ---- hw/lrcd_pkg.sv ----
// Shared constants and types of the logic, rotate and control decoder
package lrcd_pkg;

	// ==================================================================
	// Register operand field codes
	localparam logic [2:0] REG_B = 3'h0;
	localparam logic [2:0] REG_C = 3'h1;
	localparam logic [2:0] REG_D = 3'h2;
	localparam logic [2:0] REG_E = 3'h3;
	localparam logic [2:0] REG_H = 3'h4;
	localparam logic [2:0] REG_L = 3'h5;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_ACC = 3'h7;

	// ==================================================================
	// Opcode fields and fixed codes
	localparam int SRC_LSB = 0;
	localparam int DST_LSB = 3;
	localparam int FN_LSB = 3;
	localparam logic [1:0] GRP_LOGIC_REG = 2'h2;
	localparam logic [2:0] GRP_LOGIC_IMM = 3'h7;
	localparam logic [2:0] LOGIC_TAG = 3'h5;
	localparam logic [2:0] ROT_LOW = 3'h7;
	localparam logic [7:0] OPC_INV_ACC = 8'h2F;
	localparam logic [7:0] OPC_SET_CARRY = 8'h37;
	localparam logic [7:0] OPC_INV_CARRY = 8'h3F;
	localparam logic [7:0] OPC_DEC_ADJ = 8'h27;
	localparam logic [7:0] OPC_NOP = 8'h00;
	localparam logic [7:0] OPC_ALLOW_INT = 8'hFB;
	localparam logic [7:0] OPC_BLOCK_INT = 8'hF3;
	localparam logic [7:0] OPC_READ_MASK = 8'h20;
	localparam logic [7:0] OPC_WRITE_MASK = 8'h30;
	localparam logic [7:0] OPC_HALT = 8'h76;

	// Logic function select (bits 4..3)
	localparam logic [1:0] FN_AND = 2'h0;
	localparam logic [1:0] FN_XOR = 2'h1;
	localparam logic [1:0] FN_OR = 2'h2;
	localparam logic [1:0] FN_CMP = 2'h3;
	// Rotate select (bits 4..3)
	localparam logic [1:0] ROT_LEFT_CIRC = 2'h0;
	localparam logic [1:0] ROT_RIGHT_CIRC = 2'h1;
	localparam logic [1:0] ROT_LEFT_CARRY = 2'h2;
	localparam logic [1:0] ROT_RIGHT_CARRY = 2'h3;

	// ==================================================================
	// Cycle counts per instruction
	localparam logic [2:0] CYC_SHORT = 3'h4;
	localparam logic [2:0] CYC_OPERAND = 3'h7;
	localparam logic [2:0] CYC_HALT = 3'h5;
	// Count value in the state just before the second machine cycle's address state
	localparam logic [2:0] CNT_ADDR = 3'h3;

	// ==================================================================
	// Flag positions and reset values
	localparam int FLG_SIGN = 7;
	localparam int FLG_ZERO = 6;
	localparam int FLG_HALF = 4;
	localparam int FLG_PAR = 2;
	localparam int FLG_CARRY = 0;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [2:0] MASK_RST = 3'h7;

	// Write-mask operand bits
	localparam int SM_SOD_VAL = 7;
	localparam int SM_SOD_EN = 6;
	localparam int SM_MASK_EN = 3;

	// Interrupt vector codes on acceptance
	localparam logic [2:0] VEC_TRAP = 3'h4;
	localparam logic [2:0] VEC_R75 = 3'h3;
	localparam logic [2:0] VEC_R65 = 3'h2;
	localparam logic [2:0] VEC_R55 = 3'h1;
	localparam logic [2:0] VEC_GEN = 3'h0;

	// ==================================================================
	typedef enum logic [11:0] {
		CLS_OTHER = 12'h001,
		CLS_LOGIC_REG = 12'h002,
		CLS_LOGIC_MEM = 12'h004,
		CLS_LOGIC_IMM = 12'h008,
		CLS_ROTATE = 12'h010,
		CLS_SPECIAL = 12'h020,
		CLS_ALLOW_INT = 12'h040,
		CLS_BLOCK_INT = 12'h080,
		CLS_READ_MASK = 12'h100,
		CLS_WRITE_MASK = 12'h200,
		CLS_HALT = 12'h400,
		CLS_NOP = 12'h800
	} lrcd_class_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_EXEC = 4'h2,
		ST_HALTED = 4'h4,
		ST_HOLD = 4'h8
	} lrcd_state_e;

endpackage : lrcd_pkg
